// File: include/asc_pkg.sv
package asc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_STEP_INPUT_SELECT = 12'h040;
    localparam logic [11:0] ADDR_STEP_CONTROL = 12'h044;
    localparam logic [11:0] ADDR_SEQ_CMD = 12'h050;
    localparam logic [11:0] ADDR_SEQ_STATUS = 12'h054;
    localparam logic [11:0] ADDR_IRQ_RAW = 12'h058;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h05C;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int STEPS = 8;
    localparam int CTL_GROUP = 4;
    localparam int MUX_GROUP = 4;
    localparam int MUX_WIDTH = 2;
    localparam int BIT_DIFF = 0;
    localparam int BIT_LAST = 1;
    localparam int BIT_IRQ = 2;
    localparam int BIT_SENSOR = 3;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] MUX_RESET = 32'h0000_0000;
    localparam logic [31:0] MUX_MASK = 32'h3333_3333;
    localparam int IRQ_SEQ_DONE = 0;
    localparam int IRQ_STEP = 1;
    localparam int IRQ_NO_END = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_WAIT = 2'b10
    } asc_state_t;

endpackage

// File: rtl/asc_step_decode.sv
`timescale 1ns/1ps
module asc_step_decode
    import asc_pkg::*;
(
    // control fields of one step
    input wire logic [CTL_GROUP-1:0] ctl,
    input wire logic [MUX_WIDTH-1:0] mux,
    input wire logic force_last,
    // decoded request
    output logic sensor,
    output logic diff,
    output logic irq_en,
    output logic last,
    output logic [MUX_WIDTH:0] pin
);

    // sensor wins over pins; sensor never runs differential
    always_comb begin
        sensor = ctl[BIT_SENSOR]; // [R2]
        diff = ctl[BIT_DIFF] & ~ctl[BIT_SENSOR]; // [R10] [R12]
        irq_en = ctl[BIT_IRQ];
        last = ctl[BIT_LAST] | force_last; // [R6] [R9]
        // differential: pair i gives low input 2i of the pair [R11]
        if (diff) begin
            pin = {mux, 1'b0};
        end else begin
            pin = {1'b0, mux};
        end
    end

endmodule

// File: rtl/asc_seq_ctl.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// [R1] the step control word holds eight four-bit groups, step 8 on top.
// [R2] a step with sensor select converts the temperature sensor, else a pin.
// [R3] a step with interrupt enable raises the raw flag when it completes.
// [R4] the raw flag reaches the interrupt output only while its mask is set.
// [R5] several steps may raise the raw flag, each at its own completion.
// [R6] a step with its last flag set ends the sequence, at any position.
// [R7] no step after the first last-flagged step is ever requested.
// [R8] software sets a last flag somewhere before starting a sequence.
// [R9] the single-entry sequencer has its only last flag forced to one.
// [R10] a differential step samples its inputs as a pair.
// [R11] for differential steps software loads pair number i, giving 2i, 2i+1.
// [R12] the temperature sensor has no differential mode.
// [R13] each step takes its pin from its own two-bit field, step 1 lowest.
// [R14] steps run one at a time in ascending order up to the last one.
module asc_seq_ctl
    import asc_pkg::*;
#(
    parameter bit SINGLE_ENTRY = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // conversion engine
    output logic conv_req,
    output logic conv_sensor,
    output logic conv_diff,
    output logic [MUX_WIDTH:0] conv_pin,
    input wire logic conv_done,
    // interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [31:0] ctl_q, ctl_d;
    logic [31:0] mux_q, mux_d;
    logic [2:0] raw_q, raw_d;
    logic [2:0] mask_q, mask_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic irq_q, irq_d;
    asc_state_t state_q, state_d;
    logic [2:0] step_q, step_d;
    logic req_q, req_d;
    logic sensor_q, sensor_d;
    logic diff_q, diff_d;
    logic [MUX_WIDTH:0] pin_q, pin_d;

    logic [STEPS-1:0] dec_sensor, dec_diff, dec_irq, dec_last;
    logic [MUX_WIDTH:0] dec_pin [STEPS];
    logic acc, wr, rd, start;
    logic [2:0] raw_set;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == ADDR_STEP_CONTROL) || (a == ADDR_STEP_INPUT_SELECT) ||
                 (a == ADDR_SEQ_CMD) || (a == ADDR_SEQ_STATUS) ||
                 (a == ADDR_IRQ_RAW) || (a == ADDR_IRQ_MASK);
    endfunction

    // ----------------------------------------------------------------
    // per-step decode
    // ----------------------------------------------------------------
    // one decoder per group; step k sits at bits 4k+3:4k
    generate
        for (genvar k = 0; k < STEPS; k++) begin : g_step
            asc_step_decode u_dec (
                .ctl(ctl_q[k*CTL_GROUP +: CTL_GROUP]), // [R1]
                .mux(mux_q[k*MUX_GROUP +: MUX_WIDTH]), // [R13]
                .force_last(SINGLE_ENTRY && (k == 0)), // [R9]
                .sensor(dec_sensor[k]),
                .diff(dec_diff[k]),
                .irq_en(dec_irq[k]),
                .last(dec_last[k]),
                .pin(dec_pin[k])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // apb access, one wait state
    // ----------------------------------------------------------------
    // answer in the second cycle of the access phase, two cycles after setup
    always_comb begin
        acc = psel & penable & ~pready_q;
        // a write lands only at the edge where pready is seen high
        wr = psel & penable & pready_q & pwrite & mapped(paddr);
        rd = acc & ~pwrite & mapped(paddr);
        start = wr && (paddr == ADDR_SEQ_CMD) && pwdata[0] &&
                (state_q == ST_IDLE);
        pready_d = psel & penable & ~pready_q;
        pslverr_d = acc & ~mapped(paddr);
        prdata_d = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                ADDR_STEP_CONTROL: prdata_d = ctl_q;
                ADDR_STEP_INPUT_SELECT: prdata_d = mux_q;
                ADDR_SEQ_STATUS: prdata_d = {27'h0, step_q,
                                             state_q != ST_IDLE, req_q};
                ADDR_IRQ_RAW: prdata_d = {29'h0, raw_q};
                ADDR_IRQ_MASK: prdata_d = {29'h0, mask_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        ctl_d = ctl_q;
        mux_d = mux_q;
        mask_d = mask_q;
        if (wr && paddr == ADDR_STEP_CONTROL) begin
            ctl_d = pwdata;
        end
        if (wr && paddr == ADDR_STEP_INPUT_SELECT) begin
            mux_d = pwdata & MUX_MASK; // reserved bits stay zero
        end
        if (wr && paddr == ADDR_IRQ_MASK) begin
            mask_d = pwdata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // step sequencer
    // ----------------------------------------------------------------
    // one request at a time; the engine pulses conv_done when finished
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        req_d = 1'b0;
        sensor_d = sensor_q;
        diff_d = diff_q;
        pin_d = pin_q;
        raw_set = 3'h0;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    step_d = 3'h0; // [R14]
                    state_d = ST_REQ;
                end
            end
            ST_REQ: begin
                req_d = 1'b1;
                sensor_d = dec_sensor[step_q]; // [R2]
                diff_d = dec_diff[step_q]; // [R10]
                pin_d = dec_pin[step_q]; // [R13]
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_done) begin
                    raw_set[IRQ_STEP] = dec_irq[step_q]; // [R3] [R5]
                    if (dec_last[step_q]) begin
                        raw_set[IRQ_SEQ_DONE] = 1'b1;
                        state_d = ST_IDLE; // [R6] [R7]
                    end else if (step_q == 3'(STEPS - 1)) begin
                        // no last flag at all: stop and report it [R8]
                        raw_set[IRQ_NO_END] = 1'b1;
                        state_d = ST_IDLE;
                    end else begin
                        step_d = step_q + 3'h1; // [R14]
                        state_d = ST_REQ;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    // set wins over a write-one clear in the same cycle
    always_comb begin
        raw_d = raw_q;
        if (wr && paddr == ADDR_IRQ_RAW) begin
            raw_d = raw_q & ~pwdata[2:0];
        end
        raw_d = raw_d | raw_set; // [R3]
        irq_d = |(raw_d & mask_d); // [R4]
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= CTL_RESET;
            mux_q <= MUX_RESET;
            raw_q <= IRQ_RESET;
            mask_q <= IRQ_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
            state_q <= ST_IDLE;
            step_q <= 3'h0;
            req_q <= 1'b0;
            sensor_q <= 1'b0;
            diff_q <= 1'b0;
            pin_q <= '0;
        end else begin
            ctl_q <= ctl_d;
            mux_q <= mux_d;
            raw_q <= raw_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
            state_q <= state_d;
            step_q <= step_d;
            req_q <= req_d;
            sensor_q <= sensor_d;
            diff_q <= diff_d;
            pin_q <= pin_d;
        end
    end

    always_comb begin
        prdata = prdata_q;
        pready = pready_q;
        pslverr = pslverr_q;
        conv_req = req_q;
        conv_sensor = sensor_q;
        conv_diff = diff_q;
        conv_pin = pin_q;
        irq = irq_q;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_step_done;
        state_q == ST_WAIT && conv_done;
    endsequence

    sequence s_next_req;
        ##1 conv_req;
    endsequence

    a_req_decode: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        $rose(conv_req) |-> conv_sensor == ctl_q[step_q*4 + BIT_SENSOR])
        else $error("sensor select not taken from step group");
    a_sensor_no_diff: assert property (@(posedge pclk) // [R12]
        disable iff (!presetn) conv_req && conv_sensor |-> !conv_diff)
        else $error("differential request on temperature sensor");
    a_diff_follow: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        $rose(conv_req) && !conv_sensor |->
        conv_diff == ctl_q[step_q*4 + BIT_DIFF])
        else $error("differential bit not followed");
    a_pin_field: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        $rose(conv_req) && !conv_diff |->
        conv_pin[1:0] == mux_q[step_q*4 +: 2])
        else $error("pin not from step mux field");
    a_irq_step: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        s_step_done and (ctl_q[step_q*4 + BIT_IRQ] == 1'b1)
        |=> raw_q[IRQ_STEP])
        else $error("step irq not raised at completion");
    a_irq_mask: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        irq == |(raw_q & mask_q))
        else $error("irq output not gated by mask");
    a_stop_last: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        s_step_done and dec_last[step_q] |=> state_q == ST_IDLE [*2])
        else $error("sequence continued past last step");
    a_ascend: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        s_step_done and !dec_last[step_q] and step_q != 3'h7 |->
        ##1 (step_q == $past(step_q) + 3'h1) ##0 s_next_req)
        else $error("steps not run in ascending order");
    a_single_last: assert property (@(posedge pclk) // [R9]
        disable iff (!presetn) SINGLE_ENTRY |-> dec_last[0])
        else $error("single entry last flag not forced");
    a_one_req: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        conv_req |=> !conv_req)
        else $error("request longer than one cycle");

endmodule

// File: sim/asc_engine_model.sv
`timescale 1ns/1ps
module asc_engine_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request side
    input wire logic conv_req,
    input wire logic [3:0] dly,
    output logic conv_done
);
    logic [3:0] cnt_q;
    logic busy_q;

    // one done pulse per request, after a settable delay
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            conv_done <= 1'b0;
        end else if (conv_req) begin
            cnt_q <= dly;
            busy_q <= 1'b1;
            conv_done <= 1'b0;
        end else if (busy_q && cnt_q == 4'h0) begin
            busy_q <= 1'b0;
            conv_done <= 1'b1;
        end else begin
            cnt_q <= cnt_q - 4'h1;
            conv_done <= 1'b0;
        end
    end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import asc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, conv_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, ctl, mux, msk, lf;
    logic pready, pslverr, conv_req, conv_sensor, conv_diff, irq, er;
    logic [MUX_WIDTH:0] conv_pin;
    logic [3:0] dly;
    logic [4:0] q[$];
    logic s_req, s_done;
    int n_mismatch, n_tests, cyc, n_single;

    asc_seq_ctl u_asc_seq_ctl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_req(conv_req),
        .conv_sensor(conv_sensor), .conv_diff(conv_diff),
        .conv_pin(conv_pin), .conv_done(conv_done), .irq(irq));
    asc_engine_model u_asc_engine_model (.pclk(pclk), .presetn(presetn),
        .conv_req(conv_req), .dly(dly), .conv_done(conv_done));

    // second copy strapped as single entry, fed by the same bus writes
    generate
        if (1) begin : g_single
            asc_seq_ctl #(.SINGLE_ENTRY(1'b1)) u_asc_seq_ctl (.pclk(pclk),
                .presetn(presetn), .psel(psel), .penable(penable),
                .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
                .prdata(), .pready(), .pslverr(), .conv_req(s_req),
                .conv_sensor(), .conv_diff(), .conv_pin(),
                .conv_done(s_done), .irq());
            asc_engine_model u_asc_engine_model (.pclk(pclk),
                .presetn(presetn), .conv_req(s_req), .dly(dly),
                .conv_done(s_done));
        end
    endgenerate

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // a bus that never answers is a failure, not a silent return
        if (pready !== 1'b1)
            n_mismatch++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic give_verdict;
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and request monitor
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // a hung handshake must still end the run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // negedge sampling: the one-cycle request has settled
    always @(negedge pclk) begin
        if (conv_req === 1'b1)
            q.push_back({conv_sensor, conv_diff, conv_pin});
        if (s_req === 1'b1)
            n_single++;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int e, nl, ie, k;
        logic [4:0] g, x;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        dly = 4'h0;
        lf = 32'hF9144F09;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        q.delete();
        apb(0, ADDR_STEP_CONTROL, 0);
        chk("ctl reset", rd, CTL_RESET);
        apb(0, 12'h0FC, 0);
        chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
        for (int run = 0; run < 14; run++) begin
            lf = nxt(lf); ctl = lf; lf = nxt(lf); mux = lf & MUX_MASK;
            lf = nxt(lf); dly <= lf[3:0];
            // first run has no last flag at all
            if (run == 0) ctl = ctl & ~32'h2222_2222;
            else ctl = ctl | (32'h2 << (4 * lf[6:4]));
            apb(1, ADDR_STEP_CONTROL, ctl);
            apb(0, ADDR_STEP_CONTROL, 0);
            chk("ctl rw", rd, ctl);
            apb(1, ADDR_STEP_INPUT_SELECT, lf);
            apb(0, ADDR_STEP_INPUT_SELECT, 0);
            chk("mux rw", rd, lf & MUX_MASK);
            mux = lf & MUX_MASK;
            e = 7; nl = 1; ie = 0;
            for (k = 7; k >= 0; k--)
                if (ctl[4*k+1]) begin e = k; nl = 0; end
            for (k = 0; k <= e; k++) ie = ie | ctl[4*k+2];
            msk = nxt(lf) & (nl ? 32'h6 : 32'h7);
            apb(1, ADDR_IRQ_MASK, msk);
            q.delete();
            n_single = 0;
            apb(1, ADDR_SEQ_CMD, 32'h1);
            k = 0;
            do begin
                apb(0, ADDR_SEQ_STATUS, 0);
                k++;
            end while (rd[1] !== 1'b0 && k < 100);
            chk("seq idle", rd[1], 0);
            chk("single reqs", n_single, 1);
            chk("req count", q.size(), e + 1);
            for (k = 0; k <= e && q.size() > 0; k++) begin
                g = q.pop_front();
                x[4] = ctl[4*k+3];
                x[3] = ctl[4*k] & ~x[4];
                x[2:0] = x[3] ? {mux[4*k+:2], 1'b0} : {1'b0, mux[4*k+:2]};
                if (x[4]) x[2:0] = g[2:0];
                chk("step req", g, x);
            end
            apb(0, ADDR_IRQ_RAW, 0);
            chk("raw irq", rd, {29'h0, nl[0], ie[0], ~nl[0]});
            repeat (2) @(posedge pclk);
            chk("irq out", irq, |({nl[0], ie[0], ~nl[0]} & msk[2:0]));
            apb(1, ADDR_IRQ_RAW, 32'h7);
            apb(0, ADDR_IRQ_RAW, 0);
            chk("raw clr", rd, 0);
            repeat (2) @(posedge pclk);
            chk("irq clr", irq, 0);
        end
        give_verdict();
    end
endmodule
